// file: design/adc_accessory_ctl.sv
// Top of the accessory detect control block
// Contract
// - Open ID line reports code 11111; a key event then reloads convResult with the raw idCode
// - Identification waits for vbus present
// - Classify USB port, charger, dedicated charger
// - Carkit type 1/2 by ID code
// - Identification runs only above core POR
// - Store results, set event_a event
// - Event_a interrupt needs io supply, unmasked
// - Masked event_a: no interrupt, registers readable
// - Switches open before identification or with test cable
// - Switches follow host bits otherwise
// - Overvoltage: power switch off within 1us
// - Overvoltage end sets fault cleared event
// - Overtemperature: switch off, set event
// - Cool down: switch on, fault cleared
// - Seven overtemp cycles latch switch off
// - Ignore presses under 20ms or short
// - Short press event on release
// - Long press event while held
// - Long release event after long press
// - Auto power save after 10s silence
// - Manual power save when auto off
// - Keys still monitored in power save
// - Test cables auto-close UART or USB
// - Interrupt low while unmasked bit set
// - Mask bit blocks its source
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"
module adc_accessory_ctl
	import adc_pkg::*;
#(
	parameter int SHORT_CYC = 25000000,
	parameter int LONG_CYC = 250000000,
	parameter int DEBOUNCE_CYC = `ADC_DEBOUNCE_CYC,
	parameter longint IDLE_CYC = `ADC_IDLE_CYC,
	parameter int OTP_LIMIT = `ADC_OTP_LIMIT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Supplies
	input wire logic corePorOk,
	input wire logic ioSupply,
	// Detection inputs
	input wire logic vbusPresent,
	input wire logic dataLinesShorted,
	input wire logic chargingPortSeen,
	input wire logic idOpen,
	input wire logic [4:0] idCode,
	input wire logic remoteAttached,
	input wire logic detached,
	// Analog monitors, asynchronous
	input wire logic overVoltage,
	input wire logic overTemp,
	input wire logic keyDown,
	input wire logic audioActive,
	// Host controls
	input wire logic [7:0] swCtrl1,
	input wire logic [7:0] swCtrl2,
	input wire logic [`ADC_IRQ_W-1:0] irqMask,
	input wire logic irqRead,
	input wire logic autoLowPower,
	input wire logic lowPowerRequest,
	input wire logic powerSwitchReq,
	// Results and status
	output adc_pkg::adc_supply_t supplyType,
	output logic [4:0] convResult,
	output logic [`ADC_IRQ_W-1:0] irqStatus,
	output logic irq_n,
	output logic [7:0] swState1,
	output logic [7:0] swState2,
	output logic uartSwOn,
	output logic usbSwOn,
	output logic powerSwitchOn,
	output logic lowPower
);
	import adc_pkg::*;

	//------------------------------------------------------------
	// Synchronisers
	//------------------------------------------------------------
	// Monitors come from analog comparators; two flops tame metastability
	// The price is two cycles of latency on every protection path
	logic [3:0] syncd;
	logic ovSync, otSync, keySync, audSync;
	adc_sync #(.WIDTH(4)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.asyncIn({overVoltage, overTemp, keyDown, audioActive}),
		.syncOut(syncd)
	);
	assign {ovSync, otSync, keySync, audSync} = syncd;

	//------------------------------------------------------------
	// Key timing
	//------------------------------------------------------------
	// Key level is gated by remote presence so a plain cable cannot
	// raise key events; the gate ignores power save on purpose
	logic kShort, kLong, kRel;
	adc_key_timer #(
		.DEBOUNCE_CYC(DEBOUNCE_CYC),
		.SHORT_CYC(SHORT_CYC),
		.LONG_CYC(LONG_CYC)
	) u_key (
		.clock(clock),
		.rst_n(rst_n),
		.keyDown(keySync && remoteAttached),
		.shortPress(kShort),
		.longPress(kLong),
		.longRelease(kRel)
	);

	//------------------------------------------------------------
	// Identification
	//------------------------------------------------------------
	logic idDone_ff;
	logic attachPulse;
	adc_supply_t nxt_type;
	logic [4:0] effCode;
	adc_test_t testCable_ff;
	adc_test_t nxt_test;

	// Open ID line forces the all-ones code
	assign effCode = idOpen ? `ADC_CODE_OPEN : idCode;

	// Supply classification table
	always_comb begin
		nxt_type = ADC_SUP_OTHER;
		if (idOpen && effCode == `ADC_CODE_OPEN) begin
			case ({dataLinesShorted, chargingPortSeen})
				2'b00: nxt_type = ADC_SUP_USB_PORT;
				2'b01: nxt_type = ADC_SUP_CHARGING_PORT_SEEN;
				2'b10: nxt_type = ADC_SUP_DEDICATED;
				default: nxt_type = ADC_SUP_OTHER;
			endcase
		end else if (dataLinesShorted && !chargingPortSeen && !idOpen) begin
			if (effCode == `ADC_CODE_CARKIT1)
				nxt_type = ADC_SUP_CARKIT1;
			else if (effCode == `ADC_CODE_CARKIT2)
				nxt_type = ADC_SUP_CARKIT2;
		end
	end

	// Test cable decode
	always_comb begin
		case (effCode)
			`ADC_CODE_UART1, `ADC_CODE_UART2: nxt_test = ADC_SW_UART;
			`ADC_CODE_USB1, `ADC_CODE_USB2: nxt_test = ADC_SW_USB;
			default: nxt_test = ADC_SW_NONE;
		endcase
	end

	// One identification per event_a, only with core supply and vbus
	// A held event_b blocks a fresh identification until it drops
	assign attachPulse = corePorOk && vbusPresent && !idDone_ff && !detached;

	// Event_b or core supply loss rearms identification; results stay
	// readable until the next identification overwrites them; a key event also reloads convResult
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idDone_ff <= 1'b0;
			supplyType <= ADC_SUP_NONE;
			convResult <= 5'h00;
			testCable_ff <= ADC_SW_NONE;
		end else if (detached || !corePorOk) begin
			idDone_ff <= 1'b0;
			testCable_ff <= ADC_SW_NONE;
		end else begin
			if (attachPulse) begin
				idDone_ff <= 1'b1;
				supplyType <= nxt_type;
				convResult <= effCode;
				testCable_ff <= nxt_test;
			end else if (kShort || kLong || kRel)
				convResult <= idCode;
		end
	end

	//------------------------------------------------------------
	// Protection
	//------------------------------------------------------------
	logic ovDly_ff, otDly_ff;
	logic [2:0] otpCount_ff;
	logic otpLatched_ff;
	logic otRise, otFall, ovRise, ovFall;
	// Delay flops reset low, the idle level of both monitors,
	// so no false edge follows reset
	assign ovRise = ovSync && !ovDly_ff;
	assign ovFall = !ovSync && ovDly_ff;
	assign otRise = otSync && !otDly_ff;
	assign otFall = !otSync && otDly_ff;

	// Count overtemp onsets, latch off at the limit
	// Only a event_b or a reset rearms the latch
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ovDly_ff <= 1'b0;
			otDly_ff <= 1'b0;
			otpCount_ff <= 3'h0;
			otpLatched_ff <= 1'b0;
		end else begin
			ovDly_ff <= ovSync;
			otDly_ff <= otSync;
			if (detached) begin
				otpCount_ff <= 3'h0;
				otpLatched_ff <= 1'b0;
			end else if (otRise) begin
				if (otpCount_ff == 3'(OTP_LIMIT - 1))
					otpLatched_ff <= 1'b1;
				else
					otpCount_ff <= otpCount_ff + 3'h1;
			end
		end
	end

	//------------------------------------------------------------
	// Switches; sync delay plus one flop is well under 1us
	//------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			powerSwitchOn <= 1'b0;
			uartSwOn <= 1'b0;
			usbSwOn <= 1'b0;
			swState1 <= 8'h00;
			swState2 <= 8'h00;
		end else begin
			// Faults come first so no host bit can reopen the power path
			// Test cables take the switches away from the host bits
			if (ovSync || otSync || otpLatched_ff)
				powerSwitchOn <= 1'b0;
			else if (testCable_ff == ADC_SW_UART)
				powerSwitchOn <= 1'b0;
			else if (testCable_ff == ADC_SW_USB)
				powerSwitchOn <= 1'b1;
			else
				powerSwitchOn <= idDone_ff && powerSwitchReq;
			uartSwOn <= testCable_ff == ADC_SW_UART;
			usbSwOn <= testCable_ff == ADC_SW_USB;
			if (testCable_ff != ADC_SW_NONE || !idDone_ff) begin
				swState1 <= 8'h00;
				swState2 <= 8'h00;
			end else begin
				swState1 <= swCtrl1;
				swState2 <= swCtrl2;
			end
		end
	end

	//------------------------------------------------------------
	// Interrupt status, set wins over read-clear
	//------------------------------------------------------------
	// A read in the cycle of a new event keeps the new event
	// Interrupt line follows the status one cycle later, never without io
	logic [`ADC_IRQ_W-1:0] setVec;
	always_comb begin
		setVec = '0;
		setVec[`ADC_IRQ_EVENT_A] = attachPulse;
		setVec[`ADC_IRQ_SHORT] = kShort;
		setVec[`ADC_IRQ_LONG] = kLong;
		setVec[`ADC_IRQ_LREL] = kRel;
		setVec[`ADC_IRQ_OVP] = ovRise;
		setVec[`ADC_IRQ_OTP] = otRise && !otpLatched_ff;
		setVec[`ADC_IRQ_CLR] = ovFall || (otFall && !otpLatched_ff);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irqStatus <= '0;
			irq_n <= 1'b1;
		end else begin
			irqStatus <= (irqRead ? '0 : irqStatus) | setVec;
			irq_n <= !(ioSupply && |(irqStatus & ~irqMask));
		end
	end

	//------------------------------------------------------------
	// Power save
	//------------------------------------------------------------
	// Idle counter saturates so a long silence cannot wrap to active
	// Counter is held clear while no remote accessory is attached
	logic [63:0] idle_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idle_ff <= 64'h0;
			lowPower <= 1'b0;
		end else begin
			if (audSync || !remoteAttached)
				idle_ff <= 64'h0;
			else if (idle_ff != 64'(IDLE_CYC))
				idle_ff <= idle_ff + 64'h1;
			if (!autoLowPower)
				lowPower <= lowPowerRequest;
			else
				lowPower <= remoteAttached && !audSync
					&& idle_ff == 64'(IDLE_CYC);
		end
	end
endmodule // adc_accessory_ctl
`default_nettype wire

// file: design/adc_defs.svh
// Constants for the accessory detect control block
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

`define ADC_CODE_OPEN 5'h1F
`define ADC_CODE_CARKIT1 5'h17
`define ADC_CODE_CARKIT2 5'h1B
`define ADC_CODE_UART1 5'h0E
`define ADC_CODE_UART2 5'h0F
`define ADC_CODE_USB1 5'h10
`define ADC_CODE_USB2 5'h11
// Interrupt bit positions
`define ADC_IRQ_EVENT_A 0
`define ADC_IRQ_SHORT 1
`define ADC_IRQ_LONG 2
`define ADC_IRQ_LREL 3
`define ADC_IRQ_OVP 4
`define ADC_IRQ_OTP 5
`define ADC_IRQ_CLR 6
`define ADC_IRQ_W 7
// Timing, clock in MHz
`define ADC_CLK_MHZ 250
`define ADC_OVP_NS 1000
`define ADC_OVP_CYC ((`ADC_OVP_NS * `ADC_CLK_MHZ) / 1000)
`define ADC_DEBOUNCE_MS 20
`define ADC_DEBOUNCE_CYC (`ADC_DEBOUNCE_MS * `ADC_CLK_MHZ * 1000)
`define ADC_IDLE_S 10
`define ADC_IDLE_CYC (64'd`ADC_IDLE_S * 64'd`ADC_CLK_MHZ * 64'd1000000)
`define ADC_OTP_LIMIT 3'h7

`endif

// file: design/adc_pkg.sv
// Types for the accessory detect control block
package adc_pkg;
	typedef enum logic [2:0] {
		ADC_SUP_NONE,
		ADC_SUP_USB_PORT,
		ADC_SUP_CHARGING_PORT_SEEN,
		ADC_SUP_DEDICATED,
		ADC_SUP_CARKIT1,
		ADC_SUP_CARKIT2,
		ADC_SUP_OTHER
	} adc_supply_t;
	typedef enum logic [1:0] {
		ADC_SW_NONE,
		ADC_SW_UART,
		ADC_SW_USB
	} adc_test_t;
endpackage

// file: design/adc_sync.sv
// Two-flop synchroniser bank for asynchronous analog inputs
`timescale 1ns/1ns
`default_nettype none
module adc_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	// Only the second stage reads the first
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end
	assign syncOut = stage2_ff;
endmodule // adc_sync
`default_nettype wire

// file: design/adc_key_timer.sv
// Remote-control key press duration classifier
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"
module adc_key_timer #(
	parameter int DEBOUNCE_CYC = `ADC_DEBOUNCE_CYC,
	parameter int SHORT_CYC = 25000000,
	parameter int LONG_CYC = 250000000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Key level, already synchronised
	input wire logic keyDown,
	// One-cycle event pulses
	output logic shortPress,
	output logic longPress,
	output logic longRelease
);
	logic [31:0] cnt_ff;
	logic longSeen_ff;
	logic keyDly_ff;
	logic pressed_ff;

	// Debounce then time the press; counter saturates
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 32'h0;
			keyDly_ff <= 1'b0;
		end else begin
			keyDly_ff <= keyDown;
			if (!keyDown)
				cnt_ff <= 32'h0;
			else if (cnt_ff != 32'hFFFFFFFF)
				cnt_ff <= cnt_ff + 32'h1;
		end
	end

	// Press valid only past debounce plus short threshold
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pressed_ff <= 1'b0;
			longSeen_ff <= 1'b0;
			shortPress <= 1'b0;
			longPress <= 1'b0;
			longRelease <= 1'b0;
		end else begin
			shortPress <= 1'b0;
			longPress <= 1'b0;
			longRelease <= 1'b0;
			if (keyDown && cnt_ff == 32'(DEBOUNCE_CYC + SHORT_CYC))
				pressed_ff <= 1'b1;
			if (keyDown && cnt_ff == 32'(DEBOUNCE_CYC + LONG_CYC)) begin
				longPress <= 1'b1;
				longSeen_ff <= 1'b1;
			end
			if (!keyDown && keyDly_ff) begin
				shortPress <= pressed_ff && !longSeen_ff;
				longRelease <= longSeen_ff;
				pressed_ff <= 1'b0;
				longSeen_ff <= 1'b0;
			end
		end
	end
endmodule // adc_key_timer
`default_nettype wire

// file: tb/adc_accessory_ctl_sva.sv
// Port-level assertions for the accessory detect control top
`timescale 1ns/1ns
`default_nettype none
`include "adc_defs.svh"
module adc_accessory_ctl_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Watched inputs
	input wire logic corePorOk,
	input wire logic ioSupply,
	input wire logic vbusPresent,
	input wire logic idOpen,
	input wire logic detached,
	input wire logic overVoltage,
	input wire logic overTemp,
	input wire logic [6:0] irqMask,
	input wire logic irqRead,
	// Watched outputs
	input wire logic [4:0] convResult,
	input wire logic [6:0] irqStatus,
	input wire logic irq_n,
	input wire logic powerSwitchOn
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Overvoltage held through the synchroniser
	sequence ovpHeld;
		overVoltage ##1 overVoltage ##1 overVoltage;
	endsequence
	// Identification has just completed
	sequence attachSet;
		$rose(irqStatus[`ADC_IRQ_EVENT_A]);
	endsequence
	a_irq_pending_low: assert property (ioSupply && |(irqStatus & ~irqMask) |=> !irq_n)
		else $error("irq_n high with unmasked event pending");
	a_mask_blocks_irq: assert property ((irqStatus & ~irqMask) == 7'h00 |=> irq_n)
		else $error("irq_n low without unmasked event");
	a_io_off_quiet: assert property (!ioSupply |=> irq_n)
		else $error("irq_n low while io supply is off");
	a_ovp_switch_off: assert property (ovpHeld |-> ##[1:2] !powerSwitchOn)
		else $error("power switch still on under overvoltage");
	a_ovp_flag_set: assert property ($rose(overVoltage) |-> ##[2:4] irqStatus[`ADC_IRQ_OVP])
		else $error("overvoltage event not flagged");
	a_otp_switch_off: assert property ($rose(overTemp) |-> ##[2:8] !powerSwitchOn)
		else $error("power switch still on under overtemperature");
	a_otp_flag_set: assert property ($rose(overTemp) |-> ##[2:4] irqStatus[`ADC_IRQ_OTP])
		else $error("overtemperature event not flagged");
	a_id_needs_vbus: assert property (attachSet |-> $past(vbusPresent) && $past(corePorOk))
		else $error("identification without vbus or core supply");
	a_open_id_code: assert property (attachSet and $past(idOpen) |-> convResult == `ADC_CODE_OPEN)
		else $error("open ID line not reported as all ones");
	a_read_clears_flag: assert property (irqRead && !detached |=> !irqStatus[`ADC_IRQ_EVENT_A])
		else $error("event_a flag survived a status read");
endmodule // adc_accessory_ctl_sva
bind adc_accessory_ctl adc_accessory_ctl_sva i_sva (.clock(clock), .rst_n(rst_n),
	.corePorOk(corePorOk), .ioSupply(ioSupply), .vbusPresent(vbusPresent), .idOpen(idOpen),
	.detached(detached), .overVoltage(overVoltage), .overTemp(overTemp), .irqMask(irqMask),
	.irqRead(irqRead), .convResult(convResult), .irqStatus(irqStatus), .irq_n(irq_n),
	.powerSwitchOn(powerSwitchOn));
`default_nettype wire

// file: tb/adc_host_model.sv
// Host processor model that services the interrupt line
`timescale 1ns/1ns
`default_nettype none
module adc_host_model #(
	parameter int DELAY = 3
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Device side
	input wire logic irq_n,
	input wire logic [6:0] irqStatus,
	output logic irqRead,
	// Bench side
	input wire logic slow,
	input wire logic clrSeen,
	output logic [6:0] seenStatus
);
	logic [3:0] wait_ff;
	logic read_ff;
	logic [6:0] seen_ff;
	assign irqRead = read_ff;
	assign seenStatus = seen_ff;
	// Read the status after a prompt or slow delay while the line is low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff <= 4'h0;
			read_ff <= 1'b0;
		end else begin
			read_ff <= !irq_n && !read_ff && wait_ff == (slow ? 4'hC : 4'(DELAY));
			wait_ff <= (irq_n || read_ff) ? 4'h0 : wait_ff + 4'h1;
		end
	end
	// Keep what each read returned
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seen_ff <= 7'h00;
		end else if (clrSeen) begin
			seen_ff <= 7'h00;
		end else if (read_ff) begin
			seen_ff <= seen_ff | irqStatus;
		end
	end
endmodule // adc_host_model
`default_nettype wire

// file: tb/adc_accessory_ctl_tb.sv
// Self-checking bench for the accessory detect control top
`timescale 1ns/1ns
`default_nettype none
module adc_accessory_ctl_tb;
	import adc_pkg::*;
	localparam int DEB = 5;
	localparam int SHC = 10;
	localparam int LGC = 40;
	localparam int IRQ = 7;
	localparam int PWR = 10;
	localparam int LP = 11;
	localparam int ATT = 12;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic por, io, vbus, shorted, chg, idOpen, remote, detached, ovp, otp, key, audio;
	logic autoLp, lpReq, slow, clrSeen, irqRd, irq_n, uartOn, usbOn, pwrOn, lowPower, p, pReq;
	logic [4:0] code, convResult, cd;
	logic [7:0] sw1, sw2, swState1, swState2;
	logic [6:0] mask, irqStatus, seen;
	logic [12:0] obs;
	adc_supply_t supplyType;
	logic [7:0] rows [6] = '{8'h3F, 8'h7F, 8'hBF, 8'h97, 8'h9B, 8'h3F};
	logic [4:0] tcodes [4] = '{5'h0E, 5'h0F, 5'h10, 5'h11};
	int lens [3] = '{25, 8, 60};
	integer errors = 0;
	integer samples_checked = 0;
	integer seed = 32'hEE25DD66;
	integer n, k;
	assign obs = {irqStatus[0], lowPower, pwrOn, usbOn, uartOn, irq_n, seen};
	// Clock
	always #2 clock = ~clock;
	adc_accessory_ctl #(.SHORT_CYC(SHC), .LONG_CYC(LGC), .DEBOUNCE_CYC(DEB), .IDLE_CYC(50)) i_dut (
		.clock(clock), .rst_n(rst_n), .corePorOk(por), .ioSupply(io), .vbusPresent(vbus),
		.dataLinesShorted(shorted), .chargingPortSeen(chg), .idOpen(idOpen), .idCode(code),
		.remoteAttached(remote), .detached(detached), .overVoltage(ovp), .overTemp(otp),
		.keyDown(key), .audioActive(audio), .swCtrl1(sw1), .swCtrl2(sw2), .irqMask(mask),
		.irqRead(irqRd), .autoLowPower(autoLp), .lowPowerRequest(lpReq), .powerSwitchReq(pReq),
		.supplyType(supplyType), .convResult(convResult), .irqStatus(irqStatus), .irq_n(irq_n),
		.swState1(swState1), .swState2(swState2), .uartSwOn(uartOn), .usbSwOn(usbOn),
		.powerSwitchOn(pwrOn), .lowPower(lowPower));
	adc_host_model i_host (.clock(clock), .rst_n(rst_n), .irq_n(irq_n), .irqStatus(irqStatus),
		.irqRead(irqRd), .slow(slow), .clrSeen(clrSeen), .seenStatus(seen));
	// Reference model of the supply classification
	function automatic adc_supply_t expType(input logic [7:0] r);
		if (!r[5]) return (r[4:0] == 5'h17) ? ADC_SUP_CARKIT1 : ADC_SUP_CARKIT2;
		if (r[7]) return ADC_SUP_DEDICATED;
		return r[6] ? ADC_SUP_CHARGING_PORT_SEEN : ADC_SUP_USB_PORT;
	endfunction
	// Reference model of key press classification
	function automatic logic [6:0] keyBits(input int len);
		if (len <= DEB + SHC) return 7'h00;
		if (len <= DEB + LGC) return 7'h02;
		return 7'h0C;
	endfunction
	// Compare and count
	task automatic check(input string what, input logic [7:0] seenV, input logic [7:0] expV);
		samples_checked++;
		if (seenV !== expV) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, expV, seenV);
		end
	endtask
	// Verdict and end of run
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Bounded wait for one observed bit
	task automatic waitBit(input int b, input logic v);
		for (n = 0; n < 300 && obs[b] !== v; n++) @(negedge clock);
		check("wait", obs[b], v);
		if (obs[b] !== v) close_out();
	endtask
	// Clear the host record
	task automatic clr();
		@(posedge clock);
		clrSeen <= 1'b1;
		@(posedge clock);
		clrSeen <= 1'b0;
	endtask
	// Event_b, then event_a an accessory described by {short, charger, open, code}
	task automatic event_a(input logic [7:0] r);
		@(posedge clock);
		detached <= 1'b1;
		vbus <= 1'b0;
		clrSeen <= 1'b1;
		@(negedge clock);
		waitBit(ATT, 1'b0);
		@(posedge clock);
		{shorted, chg, idOpen, code} <= r;
		detached <= 1'b0;
		clrSeen <= 1'b0;
		vbus <= 1'b1;
		waitBit(ATT, 1'b1);
		repeat (2) @(negedge clock);
	endtask
	// Watchdog
	initial begin
		#200000;
		errors++;
		$display("[FAIL] run expected end seen timeout");
		close_out();
	end
	// Main sequence
	initial begin
		{por, io, vbus, idOpen, shorted, chg, remote, detached} = 8'h70;
		{ovp, otp, key, audio, autoLp, lpReq, slow, clrSeen} = 8'h00;
		pReq = 1'b1;
		{code, sw1, sw2, mask} = {5'h1F, 23'h000000};
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (10) @(negedge clock);
		check("early id", irqStatus[0], 1'b0);
		for (k = 0; k < 6; k++) begin
			@(posedge clock);
			por <= 1'b1;
			io <= (k != 4);
			mask <= {6'h00, k == 5};
			slow <= k[0];
			pReq <= (k != 2);
			sw1 <= 8'($random(seed));
			sw2 <= 8'($random(seed));
			event_a(rows[k]);
			check("type", supplyType, expType(rows[k]));
			check("code", convResult, rows[k][4:0]);
			check("test sw", {uartOn, usbOn}, 2'b00);
			check("sw1", swState1, sw1);
			check("sw2", swState2, sw2);
			check("pwr req", pwrOn, k != 2);
			repeat (4) @(negedge clock);
			if (k >= 4) check("irq quiet", irq_n, 1'b1);
			@(posedge clock);
			io <= 1'b1;
			mask <= 7'h00;
			waitBit(0, 1'b1);
		end
		for (k = 0; k < 5; k++) begin
			cd = (k < 4) ? tcodes[k] : 5'($random(seed));
			if (k == 4 && cd inside {[5'h0E:5'h11]}) cd = cd ^ 5'h08;
			event_a({3'b000, cd});
			p = cd inside {5'h0E, 5'h0F};
			waitBit(PWR, !p);
			check("uart sw", uartOn, p);
			check("usb sw", usbOn, cd inside {5'h10, 5'h11});
		end
		clr();
		@(posedge clock);
		ovp <= 1'b1;
		waitBit(PWR, 1'b0);
		check("ovp time", n < 250, 1'b1);
		waitBit(4, 1'b1);
		@(posedge clock);
		ovp <= 1'b0;
		waitBit(6, 1'b1);
		event_a(rows[0]);
		for (k = 1; k <= 7; k++) begin
			clr();
			@(posedge clock);
			otp <= 1'b1;
			waitBit(PWR, 1'b0);
			waitBit(5, 1'b1);
			@(posedge clock);
			otp <= 1'b0;
			if (k < 7) waitBit(6, 1'b1);
			waitBit(PWR, k < 7);
			repeat (20) @(negedge clock);
			check("otp latch", pwrOn, k < 7);
			check("otp clear", seen[6], k < 7);
		end
		event_a(rows[0]);
		waitBit(ATT, 1'b0);
		@(posedge clock);
		remote <= 1'b1;
		code <= 5'h05;
		for (k = 0; k < 6; k++) begin
			@(posedge clock);
			lpReq <= (k > 2);
			clr();
			@(posedge clock);
			key <= 1'b1;
			repeat (lens[k % 3]) @(posedge clock);
			key <= 1'b0;
			repeat (60) @(negedge clock);
			check("keys", seen, keyBits(lens[k % 3]));
			check("key code", convResult, 5'h05);
			check("manual save", lowPower, k > 2);
		end
		@(posedge clock);
		lpReq <= 1'b0;
		autoLp <= 1'b1;
		audio <= 1'b1;
		waitBit(LP, 1'b0);
		@(posedge clock);
		audio <= 1'b0;
		waitBit(LP, 1'b1);
		check("idle time", n > 45, 1'b1);
		@(posedge clock);
		audio <= 1'b1;
		waitBit(LP, 1'b0);
		close_out();
	end
endmodule // adc_accessory_ctl_tb
`default_nettype wire
